/* File: design/adc_seq_defs.svh */
/*
  Offsets, reset values, code limits and timing counts of the converter control block.
  Assumes a 100 MHz system clock and a 16-bit register port addressed by word index.
*/
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_MAXCONV 8'h01
`define OFS_START 8'h02
`define OFS_CHSEL0 8'h03
`define OFS_SEQ_STATUS 8'h07
`define OFS_INT_STATUS 8'h08
`define OFS_INT_ENABLE 8'h09
`define OFS_INT_CLEAR 8'h0A
`define OFS_RESULT0 8'h10

// ----------------------------------------------------------------------
// Reset values and code limits
// ----------------------------------------------------------------------
`define CONTROL_RESET 16'h0000
`define MAXCONV_RESET 16'h0000
`define CODE_MAX 12'h0FFF
`define CODE_MIN 12'h0000

// ----------------------------------------------------------------------
// Timing: shortest conversion at the converter clock rate
// ----------------------------------------------------------------------
`define CONV_TIME_NS 80
`define CONV_CLK_MHZ 25
`define CONV_TICKS ((`CONV_TIME_NS * `CONV_CLK_MHZ + 999) / 1000)

`endif

/* File: design/adc_seq_pkg.sv */
/*
  Types shared by the converter control block.
  Assumes the defs header supplies all numbers.
*/
package adc_seq_pkg;

  // Control register layout.
  typedef struct packed {
    logic [2:0] spare;
    logic ext_trig_en;
    logic [3:0] acq_prescale;
    logic [3:0] clk_prescale;
    logic start_stop;
    logic pace_every_other;
    logic cascade;
    logic clock_enable;
  } control_t;

  // Conversion engine states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACQ = 4'b0010,
    ST_CONV = 4'b0100,
    ST_STORE = 4'b1000
  } conv_state_t;

endpackage

/* File: design/adc_autosequencer_control.sv */
/*
  Control logic around one shared 12-bit sample-and-hold converter: two sequencers
  that may be cascaded, channel steering, result registers, trigger selection,
  paced interrupts and power control.
  Assumes the analog core presents an unclipped signed code on conv_raw that is
  steady by the end of the conversion window, and that trigger pins are asynchronous.
*/
// Notes on behaviour
// - One converter serialises all conversions.
// - Codes saturate to 0 and 4095.
// - Sixteen slots; in cascaded mode each picks any channel.
// - Dual eight-slot or cascaded sixteen-slot sequencer.
// - Dual mode: each sequencer uses own group.
// - Result stored in register of its slot.
// - Same channel allowed in several slots.
// - Start by software, PWM or external input.
// - Trigger A and B start own sequencers.
// - Interrupt every or every second sequence end.
// - Start/stop: each trigger continues the sequence.
// - Acquisition window has its own prescale.
// - Conversion lasts two converter clock periods.
// - Registers on system clock, sequencing on tick.
// - Reset clears enable, analog powered down.
// - Writes other than to control gated until enable set.
// - Halt powers analog down, registers kept.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

module adc_autosequencer_control (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Register port.
  input wire logic [7:0] address,
  input wire logic [15:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [15:0] read_data,
  // Trigger and halt pins.
  input wire logic trigger_channel_a,
  input wire logic trigger_channel_b,
  input wire logic external_trigger_input,
  input wire logic halt,
  // Analog core.
  input wire logic signed [13:0] conv_raw,
  output logic analog_enable,
  output logic sample_hold,
  output logic converting,
  output logic [3:0] conv_channel,
  // Interrupt.
  output logic interrupt
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Clips the raw core code into the twelve-bit output range.
  function automatic logic [11:0] sat_code(input logic signed [13:0] raw);
    if (raw <= 14'sh0000) begin
      sat_code = `CODE_MIN;
    end else if (raw >= 14'sh0FFF) begin
      sat_code = `CODE_MAX;
    end else begin
      sat_code = raw[11:0];
    end
  endfunction

  // True when a register write hits the given offset.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_prev;
  logic [13:0] raw_meta;
  logic signed [13:0] raw_sync;

  // Two flip-flops on every asynchronous input, third stage for edges.
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_prev <= 4'h0;
      raw_meta <= 14'h0000;
      raw_sync <= 14'sh0000;
    end else begin
      pin_meta <= {halt, external_trigger_input, trigger_channel_b, trigger_channel_a};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      raw_meta <= conv_raw;
      raw_sync <= raw_meta;
    end
  end

  logic [2:0] pin_rise;
  logic halt_s;
  assign pin_rise = pin_sync[2:0] & ~pin_prev[2:0];
  assign halt_s = pin_sync[3];

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  adc_seq_pkg::control_t ctrl;
  logic [15:0] maxconv;
  logic [3:0] chsel [0:15];
  logic [11:0] result [0:15];
  logic [2:0] int_status;
  logic [2:0] int_enable;
  logic wr_ok;
  logic sw_start_a;
  logic sw_start_b;

  // Other registers accept writes only while the clock enable is set.
  assign wr_ok = write_strobe && ctrl.clock_enable;
  assign sw_start_a = wr_ok && hit(address, `OFS_START) && write_data[0];
  assign sw_start_b = wr_ok && hit(address, `OFS_START) && write_data[1];

  // Control register; reset clears the clock enable.
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl <= `CONTROL_RESET;
    end else if (write_strobe && hit(address, `OFS_CONTROL)) begin
      ctrl <= write_data;
    end
  end

  // Sequence lengths and channel selections.
  always_ff @(posedge clock) begin
    if (reset) begin
      maxconv <= `MAXCONV_RESET;
      for (int i = 0; i < 16; i++) begin
        chsel[i] <= 4'h0;
      end
    end else if (wr_ok) begin
      if (hit(address, `OFS_MAXCONV)) begin
        maxconv <= write_data;
      end
      for (int r = 0; r < 4; r++) begin
        if (hit(address, `OFS_CHSEL0 + 8'(r))) begin
          for (int n = 0; n < 4; n++) begin
            chsel[4 * r + n] <= write_data[4 * n +: 4];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Converter clock tick
  // ----------------------------------------------------------------------
  logic [3:0] tick_count;
  logic tick;
  logic run;

  // The analog section runs only when enabled and not halted.
  assign run = ctrl.clock_enable && !halt_s;

  // Divides the system clock into the converter tick.
  always_ff @(posedge clock) begin
    if (reset || !run) begin
      tick_count <= 4'h0;
      tick <= 1'b0;
    end else if (tick_count >= ctrl.clk_prescale) begin
      tick_count <= 4'h0;
      tick <= 1'b1;
    end else begin
      tick_count <= tick_count + 4'h1;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Triggers
  // ----------------------------------------------------------------------
  logic trig_a;
  logic trig_b;

  // Trigger A also takes the external input; B only counts in dual mode.
  assign trig_a = sw_start_a || (ctrl.clock_enable && (pin_rise[0] ||
                  (ctrl.ext_trig_en && pin_rise[2])));
  assign trig_b = !ctrl.cascade && (sw_start_b || (ctrl.clock_enable && pin_rise[1]));

  // ----------------------------------------------------------------------
  // Sequencers
  // ----------------------------------------------------------------------
  logic busy_a;
  logic busy_b;
  logic [3:0] ptr_a;
  logic [2:0] ptr_b;
  logic [3:0] left_a;
  logic [2:0] left_b;
  logic store_a;
  logic store_b;
  logic done_a;
  logic done_b;
  logic [3:0] max_a;

  // Cascaded mode counts sixteen slots, dual mode eight.
  assign max_a = ctrl.cascade ? maxconv[3:0] : {1'b0, maxconv[2:0]};

  // Sequencer A: ignores triggers while busy, resumes in start/stop mode.
  always_ff @(posedge clock) begin
    if (reset) begin
      busy_a <= 1'b0;
      ptr_a <= 4'h0;
      left_a <= 4'h0;
      done_a <= 1'b0;
    end else begin
      done_a <= 1'b0;
      if (trig_a && !busy_a) begin
        busy_a <= 1'b1;
        left_a <= max_a;
        if (!ctrl.start_stop) begin
          ptr_a <= 4'h0;
        end
      end else if (store_a) begin
        ptr_a <= ctrl.cascade ? ptr_a + 4'h1 : {1'b0, ptr_a[2:0] + 3'h1};
        left_a <= left_a - 4'h1;
        if (left_a == 4'h0) begin
          busy_a <= 1'b0;
          done_a <= 1'b1;
          if (!ctrl.start_stop) begin
            ptr_a <= 4'h0;
          end
        end
      end
    end
  end

  // Sequencer B works on slots eight to fifteen.
  always_ff @(posedge clock) begin
    if (reset || ctrl.cascade) begin
      busy_b <= 1'b0;
      ptr_b <= 3'h0;
      left_b <= 3'h0;
      done_b <= 1'b0;
    end else begin
      done_b <= 1'b0;
      if (trig_b && !busy_b) begin
        busy_b <= 1'b1;
        left_b <= maxconv[6:4];
        if (!ctrl.start_stop) begin
          ptr_b <= 3'h0;
        end
      end else if (store_b) begin
        ptr_b <= ptr_b + 3'h1;
        left_b <= left_b - 3'h1;
        if (left_b == 3'h0) begin
          busy_b <= 1'b0;
          done_b <= 1'b1;
          if (!ctrl.start_stop) begin
            ptr_b <= 3'h0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Conversion engine
  // ----------------------------------------------------------------------
  adc_seq_pkg::conv_state_t state;
  logic cur_is_b;
  logic [3:0] cur_slot;
  logic [4:0] win_count;

  assign store_a = (state == adc_seq_pkg::ST_STORE) && !cur_is_b;
  assign store_b = (state == adc_seq_pkg::ST_STORE) && cur_is_b;

  // The single converter serves A first, then B; one conversion at a time.
  always_ff @(posedge clock) begin
    if (reset || !run) begin
      state <= adc_seq_pkg::ST_IDLE;
      cur_is_b <= 1'b0;
      cur_slot <= 4'h0;
      conv_channel <= 4'h0;
      win_count <= 5'h00;
    end else begin
      case (state)
        adc_seq_pkg::ST_IDLE: begin
          if (busy_a) begin
            cur_is_b <= 1'b0;
            cur_slot <= ptr_a;
            conv_channel <= ctrl.cascade ? chsel[ptr_a] : {1'b0, chsel[ptr_a][2:0]};
            win_count <= 5'h00;
            state <= adc_seq_pkg::ST_ACQ;
          end else if (busy_b) begin
            cur_is_b <= 1'b1;
            cur_slot <= {1'b1, ptr_b};
            conv_channel <= {1'b1, chsel[{1'b1, ptr_b}][2:0]};
            win_count <= 5'h00;
            state <= adc_seq_pkg::ST_ACQ;
          end
        end
        adc_seq_pkg::ST_ACQ: begin
          if (tick) begin
            if (win_count >= {1'b0, ctrl.acq_prescale}) begin
              win_count <= 5'h00;
              state <= adc_seq_pkg::ST_CONV;
            end else begin
              win_count <= win_count + 5'h01;
            end
          end
        end
        adc_seq_pkg::ST_CONV: begin
          if (tick) begin
            if (win_count >= 5'(`CONV_TICKS - 1)) begin
              state <= adc_seq_pkg::ST_STORE;
            end else begin
              win_count <= win_count + 5'h01;
            end
          end
        end
        adc_seq_pkg::ST_STORE: begin
          state <= adc_seq_pkg::ST_IDLE;
        end
        default: begin
          state <= adc_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Each finished conversion lands in the result register of its slot.
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        result[i] <= 12'h000;
      end
    end else if (state == adc_seq_pkg::ST_STORE) begin
      result[cur_slot] <= sat_code(raw_sync);
    end
  end

  // Analog strobes and power, all registered.
  always_ff @(posedge clock) begin
    if (reset) begin
      analog_enable <= 1'b0;
      sample_hold <= 1'b0;
      converting <= 1'b0;
    end else begin
      analog_enable <= run;
      sample_hold <= run && (state == adc_seq_pkg::ST_ACQ);
      converting <= run && (state == adc_seq_pkg::ST_CONV);
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  logic pace_a;
  logic pace_b;
  logic [2:0] int_set;
  logic [2:0] int_clr;

  // Pacing: with every-other selected, only the second end raises a flag.
  always_ff @(posedge clock) begin
    if (reset || !ctrl.pace_every_other) begin
      pace_a <= 1'b0;
      pace_b <= 1'b0;
    end else begin
      if (done_a) begin
        pace_a <= !pace_a;
      end
      if (done_b) begin
        pace_b <= !pace_b;
      end
    end
  end

  assign int_set[0] = done_a && (!ctrl.pace_every_other || pace_a);
  assign int_set[1] = done_b && (!ctrl.pace_every_other || pace_b);
  assign int_set[2] = (trig_a && busy_a) || (trig_b && busy_b);
  assign int_clr = (wr_ok && hit(address, `OFS_INT_CLEAR)) ? write_data[2:0] : 3'h0;

  // Sticky flags: a set in the clearing cycle wins.
  always_ff @(posedge clock) begin
    if (reset) begin
      int_status <= 3'h0;
    end else begin
      int_status <= (int_status & ~int_clr) | int_set;
    end
  end

  // Interrupt enable register.
  always_ff @(posedge clock) begin
    if (reset) begin
      int_enable <= 3'h0;
    end else if (wr_ok && hit(address, `OFS_INT_ENABLE)) begin
      int_enable <= write_data[2:0];
    end
  end

  // Level interrupt from the enabled flags, registered.
  always_ff @(posedge clock) begin
    if (reset) begin
      interrupt <= 1'b0;
    end else begin
      interrupt <= |(((int_status & ~int_clr) | int_set) & int_enable);
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [15:0] next_read_data;

  // Decodes the read address; unmapped words read zero.
  always_comb begin
    next_read_data = 16'h0000;
    if (address >= `OFS_RESULT0 && address <= `OFS_RESULT0 + 8'h0F) begin
      next_read_data = {4'h0, result[address[3:0]]};
    end else if (address >= `OFS_CHSEL0 && address <= `OFS_CHSEL0 + 8'h03) begin
      for (int n = 0; n < 4; n++) begin
        next_read_data[4 * n +: 4] = chsel[{address[1:0] - 2'h3, 2'(n)}];
      end
    end else begin
      case (address)
        `OFS_CONTROL: next_read_data = ctrl;
        `OFS_MAXCONV: next_read_data = maxconv;
        `OFS_SEQ_STATUS: next_read_data = {4'h0, state, busy_b, busy_a, ptr_b, ptr_a[2:0]};
        `OFS_INT_STATUS: next_read_data = {13'h0000, int_status};
        `OFS_INT_ENABLE: next_read_data = {13'h0000, int_enable};
        default: next_read_data = 16'h0000;
      endcase
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clock) begin
    if (reset || !read_strobe) begin
      read_data <= 16'h0000;
    end else begin
      read_data <= next_read_data;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_code_saturates: assert property (
    (state == adc_seq_pkg::ST_STORE && raw_sync >= 14'sh0FFF) |=> result[$past(cur_slot)] == 12'hFFF)
    else $error("high code not clipped to full scale");
  chk_one_conversion: assert property (
    !(sample_hold && converting)) else $error("sampling and converting together");
  chk_dual_group: assert property (
    (state == adc_seq_pkg::ST_ACQ && !ctrl.cascade) |-> conv_channel[3] == cur_is_b)
    else $error("channel outside sequencer group");
  chk_busy_no_restart: assert property (
    (busy_a && trig_a && !store_a) |=> ptr_a == $past(ptr_a))
    else $error("busy sequencer restarted");
  chk_conv_length: assert property (
    (state == adc_seq_pkg::ST_CONV && tick && win_count == 5'h01) |=> state == adc_seq_pkg::ST_STORE)
    else $error("conversion window wrong length");
  chk_pace_other: assert property (
    (ctrl.pace_every_other && done_a && !pace_a) |-> !int_set[0])
    else $error("first end raised flag in every-other pacing");
  chk_write_gate: assert property (
    (!ctrl.clock_enable && write_strobe && address == `OFS_INT_ENABLE) |=> $stable(int_enable))
    else $error("write taken with clock disabled");
  chk_halt_power: assert property (
    halt_s |=> !analog_enable) else $error("analog on during halt");
  chk_flag_set_wins: assert property (
    int_set[0] |=> int_status[0]) else $error("flag lost at clear");
  cov_cascade_done: cover property (ctrl.cascade && done_a);
  cov_dual_both: cover property (busy_a && busy_b);
  cov_start_stop: cover property (ctrl.start_stop && done_a ##[1:50] trig_a);

endmodule // adc_autosequencer_control

/* File: bench/adc_core_model.sv */
/*
  Behavioural analog core facing the converter control block.
  Assumes sample_hold rises before converting and the bench sets a code per channel.
*/
`timescale 1ns/1ps

module adc_core_model (
  // Clock.
  input wire logic clock,
  // Control from the block.
  input wire logic analog_enable,
  input wire logic sample_hold,
  input wire logic converting,
  input wire logic [3:0] conv_channel,
  // Unclipped code of each channel.
  input wire logic [15:0][13:0] channel_codes,
  // Core code and monitors.
  output logic signed [13:0] conv_raw,
  output logic overlap,
  output int sh_width,
  output int cv_width
);
  logic [3:0] held_channel;
  int sh_count;
  int cv_count;

  // Start from a known state.
  initial begin
    conv_raw = 14'h0000;
    held_channel = 4'h0;
    overlap = 1'h0;
    {sh_count, cv_count, sh_width, cv_width} = '0;
  end

  // ----------------------------------------------------------------------
  // Core
  // ----------------------------------------------------------------------
  // While tracking the code is noise, so a store that samples early is seen.
  always_ff @(posedge clock) begin
    if (sample_hold || !analog_enable) begin
      held_channel <= conv_channel;
      conv_raw <= ~conv_raw;
    end else begin
      conv_raw <= $signed(channel_codes[held_channel]);
    end
  end

  // ----------------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------------
  // One converter: acquisition and conversion must never overlap; widths kept.
  always_ff @(posedge clock) begin
    if (sample_hold && converting) begin
      overlap <= 1'h1;
    end
    sh_count <= sample_hold ? sh_count + 1 : 0;
    cv_count <= converting ? cv_count + 1 : 0;
    if (!sample_hold && sh_count != 0) begin
      sh_width <= sh_count;
    end
    if (!converting && cv_count != 0) begin
      cv_width <= cv_count;
    end
  end
endmodule // adc_core_model

/* File: bench/adc_autosequencer_control_test.sv */
/*
  Self-checking bench of the converter control block with an analog core model.
  Assumes the register port and timing described in the designer's hand-over.
*/
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

module adc_autosequencer_control_test;
  logic clock, reset, write_strobe, read_strobe, halt;
  logic trigger_channel_a, trigger_channel_b, external_trigger_input;
  logic [7:0] address;
  logic [15:0] write_data, read_data, rd;
  logic signed [13:0] conv_raw;
  logic analog_enable, sample_hold, converting, interrupt, overlap;
  logic [3:0] conv_channel;
  logic [15:0][13:0] channel_codes;
  logic [3:0] chan [16];
  logic [31:0] lfsr;
  int sh_width, cv_width, n_errors, compares;

  adc_autosequencer_control adc_autosequencer_control_i (.clock(clock), .reset(reset),
    .address(address), .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data), .trigger_channel_a(trigger_channel_a),
    .trigger_channel_b(trigger_channel_b), .external_trigger_input(external_trigger_input),
    .halt(halt), .conv_raw(conv_raw), .analog_enable(analog_enable),
    .sample_hold(sample_hold), .converting(converting), .conv_channel(conv_channel),
    .interrupt(interrupt));

  adc_core_model adc_core_model_i (.clock(clock), .analog_enable(analog_enable),
    .sample_hold(sample_hold), .converting(converting), .conv_channel(conv_channel),
    .channel_codes(channel_codes), .conv_raw(conv_raw), .overlap(overlap),
    .sh_width(sh_width), .cv_width(cv_width));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Expected output code: clipped to the 12-bit range.
  function automatic logic [11:0] sat(input logic signed [13:0] v);
    if (v < 0) return 12'h000;
    if (v > 14'sh0FFF) return 12'hFFF;
    return v[11:0];
  endfunction

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'h1;
    @(posedge clock);
    write_strobe <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe is taken.
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'h1;
    @(posedge clock);
    read_strobe <= 1'h0;
    #1 d = read_data;
  endtask

  // Poll a register until the masked bits match, with a bound.
  task automatic wait_reg(input logic [7:0] a, input logic [15:0] m, input logic [15:0] v);
    int i;
    for (i = 0; i < 400; i++) begin
      rd_reg(a, rd);
      if ((rd & m) === v) return;
    end
    n_errors++;
    $display("CHECK FAILED at %0t: wait on %h timed out", $time, a);
    stop_test();
  endtask

  // Pin pulses last long enough for the input synchronisers.
  task automatic trig(input int k);
    @(posedge clock);
    case (k)
      0: trigger_channel_a <= 1'h1;
      1: trigger_channel_b <= 1'h1;
      default: external_trigger_input <= 1'h1;
    endcase
    repeat (4) @(posedge clock);
    {trigger_channel_a, trigger_channel_b, external_trigger_input} <= 3'h0;
  endtask

  // Random slot channels; the last word repeats the first for oversampling.
  task automatic program_chsel();
    logic [15:0] w [4];
    for (int r = 0; r < 4; r++) begin
      lfsr = next_rand(lfsr);
      w[r] = (r == 3) ? w[0] : lfsr[15:0];
      wr(8'(`OFS_CHSEL0 + r), w[r]);
      for (int n = 0; n < 4; n++) chan[4 * r + n] = w[r][4 * n +: 4];
    end
  endtask

  task automatic check_results(input int first, input int count, input logic dual);
    logic [3:0] ch;
    for (int i = first; i < first + count; i++) begin
      rd_reg(8'(`OFS_RESULT0 + i), rd);
      ch = dual ? {i[3], chan[i][2:0]} : chan[i];
      check({4'h0, rd[11:0]}, {4'h0, sat(channel_codes[ch])});
    end
  endtask

  // ----------------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------------
  // Clock at 100 MHz.
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  // Cuts a hung run short.
  initial begin
    repeat (100000) @(posedge clock);
    n_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  // Reset, then register, sequence, trigger, pacing and halt scenarios.
  initial begin
    {write_strobe, read_strobe, halt, trigger_channel_a} = 4'h0;
    {trigger_channel_b, external_trigger_input} = 2'h0;
    address = 8'h00;
    write_data = 16'h0000;
    {n_errors, compares} = '0;
    lfsr = 32'h0001_333E;
    for (int i = 0; i < 16; i++) begin
      lfsr = next_rand(lfsr);
      channel_codes[i] = lfsr[13:0];
    end
    channel_codes[0] = 14'h3FF0;
    channel_codes[1] = 14'h1400;
    channel_codes[2] = 14'h0FFF;
    channel_codes[3] = 14'h1000;
    reset = 1'h1;
    repeat (3) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    check({14'h0, analog_enable, interrupt}, 16'h0000);
    rd_reg(`OFS_CONTROL, rd);
    check(rd, `CONTROL_RESET);
    wr(`OFS_MAXCONV, 16'h0005);
    rd_reg(`OFS_MAXCONV, rd);
    check(rd, `MAXCONV_RESET);
    wr(`OFS_INT_ENABLE, 16'h0007);
    rd_reg(`OFS_INT_ENABLE, rd);
    check(rd, 16'h0000);
    $display("test reset done");
    wr(`OFS_CONTROL, 16'h0213);
    repeat (2) @(posedge clock);
    check({15'h0, analog_enable}, 16'h0001);
    wr(`OFS_INT_ENABLE, 16'h0007);
    wr(`OFS_MAXCONV, 16'h000F);
    program_chsel();
    wr(`OFS_START, 16'h0001);
    wait_reg(`OFS_INT_STATUS, 16'h0001, 16'h0001);
    check({15'h0, interrupt}, 16'h0001);
    check(16'(sh_width), 16'h0006);
    check(16'(cv_width), 16'h0004);
    check({15'h0, overlap}, 16'h0000);
    check_results(0, 16, 1'h0);
    wr(`OFS_INT_CLEAR, 16'h0007);
    wr(`OFS_INT_ENABLE, 16'h0000);
    wr(`OFS_START, 16'h0001);
    wait_reg(`OFS_INT_STATUS, 16'h0001, 16'h0001);
    check({15'h0, interrupt}, 16'h0000);
    wr(`OFS_INT_ENABLE, 16'h0007);
    repeat (2) @(posedge clock);
    check({15'h0, interrupt}, 16'h0001);
    wr(`OFS_INT_CLEAR, 16'h0007);
    @(posedge clock);
    check({15'h0, interrupt}, 16'h0000);
    $display("test cascade done");
    wr(`OFS_CONTROL, 16'h1031);
    wr(`OFS_MAXCONV, 16'h0012);
    program_chsel();
    trig(2);
    trig(1);
    wait_reg(`OFS_INT_STATUS, 16'h0003, 16'h0003);
    check_results(0, 3, 1'h1);
    check_results(8, 2, 1'h1);
    wr(`OFS_INT_CLEAR, 16'h0007);
    wr(`OFS_START, 16'h0001);
    trig(0);
    wait_reg(`OFS_INT_STATUS, 16'h0001, 16'h0001);
    rd_reg(`OFS_INT_STATUS, rd);
    check(rd, 16'h0005);
    wr(`OFS_INT_CLEAR, 16'h0007);
    $display("test dual done");
    wr(`OFS_CONTROL, 16'h0005);
    wr(`OFS_START, 16'h0001);
    wait_reg(`OFS_SEQ_STATUS, 16'h0040, 16'h0000);
    repeat (3) @(posedge clock);
    rd_reg(`OFS_INT_STATUS, rd);
    check(rd, 16'h0000);
    wr(`OFS_START, 16'h0001);
    wait_reg(`OFS_INT_STATUS, 16'h0001, 16'h0001);
    $display("test pacing done");
    halt <= 1'h1;
    repeat (4) @(posedge clock);
    check({15'h0, analog_enable}, 16'h0000);
    rd_reg(`OFS_CONTROL, rd);
    check(rd, 16'h0005);
    halt <= 1'h0;
    wr(8'h3F, 16'hFFFF);
    rd_reg(8'h3F, rd);
    check(rd, 16'h0000);
    $display("test halt done");
    // Start/stop: the slot pointer carries on from where the last sequence ended.
    wr(`OFS_INT_CLEAR, 16'h0007);
    wr(`OFS_CONTROL, 16'h0039);
    wr(`OFS_MAXCONV, 16'h0001);
    for (int k = 1; k < 3; k++) begin
      wr(`OFS_START, 16'h0001);
      wait_reg(`OFS_INT_STATUS, 16'h0001, 16'h0001);
      wr(`OFS_INT_CLEAR, 16'h0001);
      rd_reg(`OFS_SEQ_STATUS, rd);
      check({13'h0, rd[2:0]}, 16'(2 * k));
    end
    check_results(2, 2, 1'h1);
    $display("test start/stop done");
    stop_test();
  end
endmodule // adc_autosequencer_control_test
